// ==== rtl/tsens_regs_pkg.sv ====
// constants for the sensor offset, scratch and identification register bank
`default_nettype none
package tsens_regs_pkg;
	localparam int WORD_W = 16;
	// register pointers
	localparam logic [7:0] REG_RESULT = 8'h00;
	localparam logic [7:0] REG_HIGH_LIMIT = 8'h02;
	localparam logic [7:0] REG_LOW_LIMIT = 8'h03;
	localparam logic [7:0] REG_UNLOCK = 8'h04;
	localparam logic [7:0] REG_SCRATCH_TWO = 8'h06;
	localparam logic [7:0] REG_OFFSET = 8'h07;
	localparam logic [7:0] REG_SCRATCH_THREE = 8'h08;
	localparam logic [7:0] REG_IDENT = 8'h0F;
	// field positions
	localparam int UNLOCK_BIT = 15;
	localparam int NV_BUSY_BIT = 14;
	localparam int REV_LSB = 12;
	// values after reset, and the clamp limits
	localparam logic [15:0] RESULT_RESET = 16'h8000;
	localparam logic [15:0] HIGH_LIMIT_RESET = 16'h6000;
	localparam logic [15:0] LOW_LIMIT_RESET = 16'h8000;
	localparam logic [15:0] OFFSET_RESET = 16'h0000;
	localparam logic [15:0] WORD_MAX = 16'h7FFF;
	localparam logic [15:0] WORD_MIN = 16'h8000;
	// bus protocol values
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
	localparam logic [7:0] GENERAL_RESET_CMD = 8'h06;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// non-volatile programming busy time in mclk cycles
	localparam logic [7:0] NV_PROG_CYCLES = 8'h10;
	typedef enum logic [2:0] {
		st_idle,
		st_addr,
		st_ack_addr,
		st_rx,
		st_ack_rx,
		st_tx,
		st_ack_tx
	} bus_state_e;
endpackage : tsens_regs_pkg
`default_nettype wire

// ==== rtl/bit_sync.sv ====
// two-flop synchroniser for pin levels entering the mclk domain
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			meta <= '1;
			sync_out <= '1;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule : bit_sync
`default_nettype wire

// ==== rtl/sat_add16.sv ====
// signed 16-bit add that clamps instead of wrapping
`default_nettype none
module sat_add16 (
	input wire logic [15:0] a,
	input wire logic [15:0] b,
	output logic [15:0] sum
);
	import tsens_regs_pkg::*;
	logic [16:0] wide;
	always_comb begin
		wide = {a[15], a} + {b[15], b};
		// sign of 17-bit sum differs from bit 15 only on overflow
		if (wide[16] != wide[15]) begin
			sum = wide[16] ? WORD_MIN : WORD_MAX;
		end else begin
			sum = wide[15:0];
		end
	end
endmodule : sat_add16
`default_nettype wire

// ==== rtl/sensor_offset_scratch_id_regs.sv ====
// two-wire slave register bank: offset, scratch words, identification, alert
`default_nettype none
// Functional notes
// - offset added after linearization to each result
// - offset LSB and span match temperature result
// - offset uses the result register data format
// - negative values are 16-bit two's complement
// - out-of-range sums clamp to max or min
// - offset is 16-bit read/write, zero after reset
// - scratch two read/write, reset value from storage
// - scratch three at 08h behaves like scratch two
// - locked writes volatile only; unlocked writes program storage
// - unlock bit resets locked; set routes writes to storage
// - identification at 0Fh is read-only
// - identification bits 15:12 hold silicon revision
// - identification bits 11:0 hold fixed part code
// - device is only a slave; host clocks
// - clock input, data open-drain, alert driven output
// - address-select pin picks one of four addresses
// - alert asserts when result crosses limits 02h/03h
module sensor_offset_scratch_id_regs #(
	parameter logic [6:0] BUS_ADDR_BASE = 7'h48,
	parameter logic [3:0] SILICON_REV = 4'h0,
	// arbitrary part code, not any real device's
	parameter logic [11:0] PART_CODE = 12'hA5C
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic address_select_pin,
	input wire logic [15:0] raw_temp,
	input wire logic raw_valid,
	output logic sda_out,
	output logic sda_oe_n,
	output logic alert_n,
	output logic [15:0] temp_result
);
	import tsens_regs_pkg::*;

	logic scl_s, sda_s, pin_s, scl_q, sda_q;
	logic scl_rise, scl_fall, start_seen, stop_seen;
	bus_state_e state, next_state;
	logic [3:0] bitcnt, next_bitcnt;
	logic [1:0] byte_idx, next_byte_idx;
	logic [7:0] rx_sr, next_rx_sr, msb_hold, next_msb_hold;
	logic [7:0] ptr, next_ptr;
	logic [15:0] tx_sr, next_tx_sr;
	logic rw_read, next_rw_read, gen_call, next_gen_call;
	logic next_sda_oe_n, next_alert_n, next_sda_out;
	logic diff_scl, next_diff_scl, diff_sda, next_diff_sda, seen_high, next_seen_high;
	logic [1:0] sel;
	logic [15:0] next_temp_result, high_limit, next_high_limit, low_limit, next_low_limit;
	logic [15:0] offset_word, next_offset_word, scratch_two, next_scratch_two;
	logic [15:0] scratch_three, next_scratch_three, rd_word, sat_sum, wdata;
	logic [16:0] sum_wide;
	logic unlock, next_unlock, soft_rst, next_soft_rst;
	logic [7:0] busy_cnt, next_busy_cnt;
	logic [15:0] nv_mem [0:1];
	logic nv_we, nv_idx;
	logic wr_commit;

	bit_sync #(.W(3)) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.async_in({scl_in, sda_in, address_select_pin}),
		.sync_out({scl_s, sda_s, pin_s})
	);

	sat_add16 u_add (
		.a(raw_temp),
		.b(offset_word),
		.sum(sat_sum)
	);

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;
	assign wdata = {msb_hold, rx_sr};
	// sign-extended sum: bits 16 and 15 agree only when no clamp is due
	assign sum_wide = {raw_temp[15], raw_temp} + {offset_word[15], offset_word};

	// pin that follows scl or sda over the address byte selects that address
	always_comb begin
		if (!diff_scl) begin
			sel = 2'h3;
		end else if (!diff_sda) begin
			sel = 2'h2;
		end else if (seen_high) begin
			sel = 2'h1;
		end else begin
			sel = 2'h0;
		end
	end

	always_comb begin
		if (ptr == REG_RESULT) begin
			rd_word = temp_result;
		end else if (ptr == REG_HIGH_LIMIT) begin
			rd_word = high_limit;
		end else if (ptr == REG_LOW_LIMIT) begin
			rd_word = low_limit;
		end else if (ptr == REG_UNLOCK) begin
			rd_word = 16'h0000;
			rd_word[UNLOCK_BIT] = unlock;
			rd_word[NV_BUSY_BIT] = (busy_cnt != 8'h00);
		end else if (ptr == REG_SCRATCH_TWO) begin
			rd_word = scratch_two;
		end else if (ptr == REG_OFFSET) begin
			rd_word = offset_word;
		end else if (ptr == REG_SCRATCH_THREE) begin
			rd_word = scratch_three;
		end else if (ptr == REG_IDENT) begin
			rd_word = {SILICON_REV, PART_CODE};
		end else begin
			rd_word = 16'h0000;
		end
	end

	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_byte_idx = byte_idx;
		next_rx_sr = rx_sr;
		next_msb_hold = msb_hold;
		next_ptr = ptr;
		next_tx_sr = tx_sr;
		next_rw_read = rw_read;
		next_gen_call = gen_call;
		next_sda_oe_n = sda_oe_n;
		next_sda_out = 1'b0;
		next_diff_scl = diff_scl;
		next_diff_sda = diff_sda;
		next_seen_high = seen_high;
		next_soft_rst = 1'b0;
		wr_commit = 1'b0;
		// slave only: every move is paced by the host's scl edges or its start and stop conditions
		case (state)
			st_addr: begin
				next_diff_scl = diff_scl | (pin_s != scl_s);
				next_diff_sda = diff_sda | (pin_s != sda_s);
				next_seen_high = seen_high | pin_s;
				if (scl_rise) begin
					next_rx_sr = {rx_sr[6:0], sda_s};
					next_bitcnt = bitcnt + 4'h1;
				end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
					next_rw_read = rx_sr[0];
					next_gen_call = (rx_sr[7:1] == GENERAL_CALL_ADDR) && !rx_sr[0];
					if (rx_sr[7:1] == {BUS_ADDR_BASE[6:2], sel} || next_gen_call) begin
						next_sda_oe_n = 1'b0;
						next_state = st_ack_addr;
					end else begin
						next_state = st_idle;
					end
				end
			end
			st_ack_addr: begin
				if (scl_fall) begin
					next_bitcnt = 4'h0;
					next_byte_idx = 2'h0;
					if (rw_read) begin
						next_sda_oe_n = rd_word[15];
						next_tx_sr = {rd_word[14:0], rd_word[15]};
						next_bitcnt = 4'h1;
						next_state = st_tx;
					end else begin
						next_sda_oe_n = 1'b1;
						next_state = st_rx;
					end
				end
			end
			st_rx: begin
				if (scl_rise) begin
					next_rx_sr = {rx_sr[6:0], sda_s};
					next_bitcnt = bitcnt + 4'h1;
				end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
					next_bitcnt = 4'h0;
					next_sda_oe_n = 1'b0;
					next_state = st_ack_rx;
					if (gen_call) begin
						next_soft_rst = (rx_sr == GENERAL_RESET_CMD);
					end else if (byte_idx == 2'h0) begin
						next_ptr = rx_sr;
						next_byte_idx = 2'h1;
					end else if (byte_idx == 2'h1) begin
						next_msb_hold = rx_sr;
						next_byte_idx = 2'h2;
					end else begin
						wr_commit = 1'b1;
						next_byte_idx = 2'h1;
					end
				end
			end
			st_ack_rx: begin
				if (scl_fall) begin
					next_sda_oe_n = 1'b1;
					next_state = st_rx;
				end
			end
			st_tx: begin
				if (scl_fall) begin
					if (bitcnt == BITS_PER_BYTE) begin
						next_sda_oe_n = 1'b1;
						next_state = st_ack_tx;
					end else begin
						next_sda_oe_n = tx_sr[15];
						next_tx_sr = {tx_sr[14:0], tx_sr[15]};
						next_bitcnt = bitcnt + 4'h1;
					end
				end
			end
			st_ack_tx: begin
				if (scl_rise && sda_s) begin
					next_state = st_idle;
				end else if (scl_fall) begin
					next_sda_oe_n = tx_sr[15];
					next_tx_sr = {tx_sr[14:0], tx_sr[15]};
					next_bitcnt = 4'h1;
					next_state = st_tx;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		if (start_seen) begin
			next_state = st_addr;
			next_bitcnt = 4'h0;
			next_sda_oe_n = 1'b1;
			next_diff_scl = 1'b0;
			next_diff_sda = 1'b0;
			next_seen_high = 1'b0;
		end else if (stop_seen) begin
			next_state = st_idle;
			next_sda_oe_n = 1'b1;
		end
	end

	always_comb begin
		next_temp_result = temp_result;
		next_high_limit = high_limit;
		next_low_limit = low_limit;
		next_offset_word = offset_word;
		next_scratch_two = scratch_two;
		next_scratch_three = scratch_three;
		next_unlock = unlock;
		next_busy_cnt = (busy_cnt != 8'h00) ? busy_cnt - 8'h01 : 8'h00;
		nv_we = 1'b0;
		nv_idx = 1'b0;
		// raw input is already linearized; offset joins afterwards
		if (raw_valid) begin
			next_temp_result = sat_sum;
		end
		if (wr_commit) begin
			if (ptr == REG_HIGH_LIMIT) begin
				next_high_limit = wdata;
			end else if (ptr == REG_LOW_LIMIT) begin
				next_low_limit = wdata;
			end else if (ptr == REG_UNLOCK) begin
				next_unlock = wdata[UNLOCK_BIT];
			end else if (ptr == REG_OFFSET) begin
				next_offset_word = wdata;
			end else if (ptr == REG_SCRATCH_TWO) begin
				next_scratch_two = wdata;
				nv_we = unlock;
			end else if (ptr == REG_SCRATCH_THREE) begin
				next_scratch_three = wdata;
				nv_we = unlock;
				nv_idx = 1'b1;
			end
			// identification and result pointers take the write and keep their value
			if (nv_we) begin
				next_busy_cnt = NV_PROG_CYCLES;
			end
		end
		// comparator: alert holds while result sits outside the limits
		next_alert_n = !(($signed(temp_result) > $signed(high_limit)) ||
			($signed(temp_result) < $signed(low_limit)));
		if (soft_rst) begin
			next_temp_result = RESULT_RESET;
			next_high_limit = HIGH_LIMIT_RESET;
			next_low_limit = LOW_LIMIT_RESET;
			next_offset_word = OFFSET_RESET;
			next_unlock = 1'b0;
			next_scratch_two = nv_mem[0];
			next_scratch_three = nv_mem[1];
			next_alert_n = 1'b1;
		end
	end

	// storage keeps its contents over reset, so it has no reset branch
	always_ff @(posedge mclk) begin
		if (nv_we) begin
			nv_mem[nv_idx] <= wdata;
		end
	end

	always_ff @(posedge mclk) begin
		scl_q <= scl_s;
		sda_q <= sda_s;
		if (!rstn) begin
			state <= st_idle;
			bitcnt <= 4'h0;
			byte_idx <= 2'h0;
			rx_sr <= 8'h00;
			msb_hold <= 8'h00;
			ptr <= 8'h00;
			tx_sr <= 16'h0000;
			rw_read <= 1'b0;
			gen_call <= 1'b0;
			sda_oe_n <= 1'b1;
			sda_out <= 1'b0;
			diff_scl <= 1'b0;
			diff_sda <= 1'b0;
			seen_high <= 1'b0;
			soft_rst <= 1'b1;
			busy_cnt <= 8'h00;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			byte_idx <= next_byte_idx;
			rx_sr <= next_rx_sr;
			msb_hold <= next_msb_hold;
			ptr <= next_ptr;
			tx_sr <= next_tx_sr;
			rw_read <= next_rw_read;
			gen_call <= next_gen_call;
			sda_oe_n <= next_sda_oe_n;
			sda_out <= next_sda_out;
			diff_scl <= next_diff_scl;
			diff_sda <= next_diff_sda;
			seen_high <= next_seen_high;
			soft_rst <= next_soft_rst;
			busy_cnt <= next_busy_cnt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			temp_result <= RESULT_RESET;
			high_limit <= HIGH_LIMIT_RESET;
			low_limit <= LOW_LIMIT_RESET;
			offset_word <= OFFSET_RESET;
			unlock <= 1'b0;
			alert_n <= 1'b1;
			scratch_two <= 16'h0000;
			scratch_three <= 16'h0000;
		end else begin
			temp_result <= next_temp_result;
			high_limit <= next_high_limit;
			low_limit <= next_low_limit;
			offset_word <= next_offset_word;
			unlock <= next_unlock;
			alert_n <= next_alert_n;
			scratch_two <= next_scratch_two;
			scratch_three <= next_scratch_three;
		end
	end

	AST_OFFSET_ZERO_AFTER_RESET: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(rstn) |-> offset_word == OFFSET_RESET && !unlock)
		else $error("offset or unlock not cleared by reset");
	AST_UNLOCK_AFTER_RESET: assert property (@(posedge mclk) disable iff (!rstn)
		soft_rst |=> !unlock)
		else $error("unlock bit not cleared by reset");
	AST_SUM_IN_RANGE: assert property (@(posedge mclk) disable iff (!rstn)
		raw_valid && !soft_rst && sum_wide[16] == sum_wide[15] |=>
		temp_result == $past(raw_temp) + $past(offset_word))
		else $error("result is not raw plus offset");
	AST_CLAMP_HIGH: assert property (@(posedge mclk) disable iff (!rstn)
		raw_valid && !soft_rst && !raw_temp[15] && !offset_word[15] &&
		(raw_temp + offset_word) >= WORD_MIN |=> temp_result == WORD_MAX)
		else $error("positive overflow did not clamp");
	AST_CLAMP_LOW: assert property (@(posedge mclk) disable iff (!rstn)
		raw_valid && !soft_rst && raw_temp[15] && offset_word[15] &&
		(raw_temp + offset_word) <= WORD_MAX |=> temp_result == WORD_MIN)
		else $error("negative overflow did not clamp");
	AST_LOCKED_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
		wr_commit && !unlock && ptr == REG_SCRATCH_THREE |->
		!nv_we ##1 scratch_three == $past(wdata) && busy_cnt == 8'h00)
		else $error("locked write reached storage");
	AST_UNLOCKED_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
		wr_commit && unlock && (ptr == REG_SCRATCH_TWO || ptr == REG_SCRATCH_THREE) |=>
		nv_mem[$past(nv_idx)] == $past(wdata) && busy_cnt == NV_PROG_CYCLES)
		else $error("unlocked write did not program storage");
	AST_IDENT_FIXED: assert property (@(posedge mclk) disable iff (!rstn)
		ptr == REG_IDENT |-> rd_word[REV_LSB-1:0] == PART_CODE && rd_word[15:REV_LSB] == SILICON_REV)
		else $error("identification word wrong");
	AST_ALERT_HIGH: assert property (@(posedge mclk) disable iff (!rstn)
		$signed(temp_result) > $signed(high_limit) && !soft_rst |=> !alert_n)
		else $error("alert missed high crossing");
	AST_ACK_DRIVES: assert property (@(posedge mclk) disable iff (!rstn)
		state != st_ack_addr ##1 state == st_ack_addr |-> !sda_oe_n && !sda_out)
		else $error("address ack not driven low");
endmodule : sensor_offset_scratch_id_regs
`default_nettype wire

// ==== dv/bus_host_model.sv ====
// two-wire bus host model: makes the bus clock and pulls data low open-drain
`default_nettype none
module bus_host_model (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ns;
	logic acks_ok;
	// clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		acks_ok = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// 8 mclk per bit; data moves only while the clock is low
	task automatic bit_xfer(input logic b, output logic got);
		scl <= 1'b0;
		tick(1);
		sda_low <= ~b;
		tick(3);
		scl <= 1'b1;
		tick(3);
		got = sda;
		tick(1);
	endtask : bit_xfer
	task automatic start_cond();
		acks_ok = 1'b1;
		sda_low <= 1'b0;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
	endtask : start_cond
	task automatic stop_cond();
		scl <= 1'b0;
		tick(1);
		sda_low <= 1'b1;
		tick(3);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(8);
	endtask : stop_cond
	task automatic send_byte(input logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) bit_xfer(d[i], g);
		bit_xfer(1'b1, g);
		acks_ok = acks_ok & ~g;
	endtask : send_byte
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
		bit_xfer(last, g);
	endtask : recv_byte
endmodule : bus_host_model
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the offset, scratch and identification register bank
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tsens_regs_pkg::*;
	localparam logic [6:0] BASE = 7'h48;
	localparam logic [3:0] REV = 4'h3;
	// arbitrary part code, chosen for the bench
	localparam logic [11:0] CODE = 12'h5A1;
	localparam logic [15:0] CORNER [6] = '{16'h7F00, 16'h0200, 16'h8100, 16'hFE00, 16'h0010, 16'hFFF0};
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic raw_valid = 1'b0;
	logic [15:0] raw_temp = 16'h0000;
	logic [1:0] pin_mode = 2'h0;
	logic scl, sda_low, sda, pin, sda_out, sda_oe_n, alert_n;
	logic [15:0] temp_result;
	logic [31:0] lfsr = 32'h6C5AC3B8;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #25 mclk = ~mclk;
	// pull-up wins unless either party pulls low
	assign sda = (sda_low || sda_oe_n === 1'b0) ? 1'b0 : 1'b1;
	assign pin = pin_mode[1] ? (pin_mode[0] ? scl : sda) : pin_mode[0];
	bus_host_model bus_host_model_inst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
	sensor_offset_scratch_id_regs #(.BUS_ADDR_BASE(BASE), .SILICON_REV(REV), .PART_CODE(CODE))
		sensor_offset_scratch_id_regs_inst (.mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
		.address_select_pin(pin), .raw_temp(raw_temp), .raw_valid(raw_valid), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .alert_n(alert_n), .temp_result(temp_result));
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction : next_rand
	// same-sign overflow clamps toward the sign of the operands
	function automatic logic [15:0] sat_sum(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] s;
		s = a + b;
		if (a[15] == b[15] && s[15] != a[15]) return a[15] ? WORD_MIN : WORD_MAX;
		return s;
	endfunction : sat_sum
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors++;
			$display("unexpected hang at %0t", $time);
			complete_run();
		end
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d);
		bus_host_model_inst.start_cond();
		bus_host_model_inst.send_byte({a, 1'b0});
		bus_host_model_inst.send_byte(p);
		bus_host_model_inst.send_byte(d[15:8]);
		bus_host_model_inst.send_byte(d[7:0]);
		bus_host_model_inst.stop_cond();
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d);
		bus_host_model_inst.start_cond();
		bus_host_model_inst.send_byte({a, 1'b0});
		bus_host_model_inst.send_byte(p);
		bus_host_model_inst.stop_cond();
		bus_host_model_inst.start_cond();
		bus_host_model_inst.send_byte({a, 1'b1});
		bus_host_model_inst.recv_byte(1'b0, d[15:8]);
		bus_host_model_inst.recv_byte(1'b1, d[7:0]);
		bus_host_model_inst.stop_cond();
	endtask : rd
	// result lands one edge after the pulse, alert one edge later
	task automatic apply_raw(input logic [15:0] r);
		raw_temp <= r;
		raw_valid <= 1'b1;
		@(posedge mclk);
		raw_valid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : apply_raw
	initial begin
		logic [15:0] d, off, raw, exp;
		logic hot;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		repeat (6) @(posedge mclk);
		rd(BASE, REG_OFFSET, d);
		check(d, OFFSET_RESET, "offset reset");
		rd(BASE, REG_UNLOCK, d);
		check(d, 16'h0000, "unlock reset");
		rd(BASE, REG_IDENT, d);
		check(d, {REV, CODE}, "identification");
		wr(BASE, REG_IDENT, ~{REV, CODE});
		check({15'h0, bus_host_model_inst.acks_ok}, 16'h0001, "ident ack");
		rd(BASE, REG_IDENT, d);
		check(d, {REV, CODE}, "ident kept");
		check({15'h0, sda_out}, 16'h0000, "data drive level");
		$display("test identification ended");
		for (int i = 0; i < 14; i++) begin
			lfsr = next_rand(lfsr);
			off = i < 3 ? CORNER[2 * i + 1] : lfsr[15:0];
			raw = i < 3 ? CORNER[2 * i] : lfsr[31:16];
			wr(BASE, REG_OFFSET, off);
			rd(BASE, REG_OFFSET, d);
			check(d, off, "offset readback");
			apply_raw(raw);
			exp = sat_sum(raw, off);
			check(temp_result, exp, "result");
			hot = $signed(exp) > $signed(HIGH_LIMIT_RESET);
			check({15'h0, alert_n}, {15'h0, ~hot}, "alert");
		end
		$display("test offset and alert ended");
		for (int i = 0; i < 2; i++) begin
			lfsr = next_rand(lfsr);
			wr(BASE, i ? REG_SCRATCH_THREE : REG_SCRATCH_TWO, lfsr[15:0]);
			rd(BASE, i ? REG_SCRATCH_THREE : REG_SCRATCH_TWO, d);
			check(d, lfsr[15:0], "scratch");
		end
		wr(BASE, REG_UNLOCK, 16'h8000);
		rd(BASE, REG_UNLOCK, d);
		check({15'h0, d[UNLOCK_BIT]}, 16'h0001, "unlock set");
		wr(BASE, REG_SCRATCH_THREE, 16'hC3A5);
		wr(BASE, REG_UNLOCK, 16'h0000);
		wr(BASE, REG_SCRATCH_THREE, 16'h1E0F);
		rd(BASE, REG_SCRATCH_THREE, d);
		check(d, 16'h1E0F, "locked write");
		bus_host_model_inst.start_cond();
		bus_host_model_inst.send_byte({GENERAL_CALL_ADDR, 1'b0});
		bus_host_model_inst.send_byte(GENERAL_RESET_CMD);
		bus_host_model_inst.stop_cond();
		rd(BASE, REG_SCRATCH_THREE, d);
		check(d, 16'hC3A5, "stored word");
		rd(BASE, REG_OFFSET, d);
		check(d, OFFSET_RESET, "offset after soft reset");
		$display("test scratch and storage ended");
		for (int m = 0; m < 4; m++) begin
			pin_mode <= 2'(m);
			@(posedge mclk);
			wr(BASE | 7'(m), REG_OFFSET, 16'(m + 5));
			check({15'h0, bus_host_model_inst.acks_ok}, 16'h0001, "own address");
			wr(BASE | 7'((m + 1) % 4), REG_OFFSET, 16'h0000);
			check({15'h0, bus_host_model_inst.acks_ok}, 16'h0000, "other address");
			rd(BASE | 7'(m), REG_OFFSET, d);
			check(d, 16'(m + 5), "address readback");
		end
		$display("test address select ended");
		complete_run();
	end
endmodule : tb
`default_nettype wire
